// ===== hdl/psu_ctrl_pkg.sv
package psu_ctrl_pkg;

    // --------------------------------------------------------------
    // Converter scaling: 12-bit codes, 1 LSB = 1 mV on 0..3.3 V pins
    // --------------------------------------------------------------
    localparam int                ADC_W         = 12;
    localparam int                SHELF_W       = 16;
    localparam int                NIB_W         = 4;
    localparam int                IDX_W         = 4;
    localparam int                SET_W         = 16;

    // Bay / slot thresholds, millivolts, midway between levels
    localparam logic [ADC_W-1:0]  BAY_INVALID_MV = 12'hC4E; // 3150
    localparam logic [ADC_W-1:0]  BAY_STEP_MV    = 12'h14A; // 330
    localparam logic [ADC_W-1:0]  BAY_TOP_MV     = 12'hB13; // 2835 (bay1/2)
    // Rack thresholds: midpoints of 3.3/2.8/2.3/1.8/1.4/1.0/0.5/0
    localparam logic [ADC_W-1:0]  RACK_THR [7] = '{
        12'hBEA, 12'h9F6, 12'h802, 12'h640, 12'h4B0, 12'h2EE, 12'h0FA};

    // Shelf input, 10 mV per LSB; window min/max per shelf
    localparam logic [SHELF_W-1:0] SHELF_MIN [10] = '{
        16'h00E6, 16'h01D6, 16'h02E4, 16'h03B6, 16'h049C,
        16'h058C, 16'h067C, 16'h076C, 16'h0852, 16'h094C};
    localparam logic [SHELF_W-1:0] SHELF_MAX [10] = '{
        16'h010E, 16'h0212, 16'h02F8, 16'h041A, 16'h0528,
        16'h062C, 16'h0730, 16'h0834, 16'h0938, 16'h0A46};

    // Setpoint pin and output scaling (pin mV, output in 10 mV)
    localparam logic [ADC_W-1:0]  SETP_HIGH_MV  = 12'hBB8; // 3000
    localparam logic [ADC_W-1:0]  SETP_LOW_MV   = 12'h064; // 100
    localparam logic [SET_W-1:0]  VOUT_MIN_CV   = 16'h08FC; // 23.00 V
    localparam logic [SET_W-1:0]  VOUT_DEF_CV   = 16'h08FC; // 23 V
    localparam logic [SET_W-1:0]  VOUT_SPAN_CV  = 16'h1068; // 42.00 V
    localparam logic [SET_W-1:0]  VOUT_MAX_STEP = 16'h03E8; // 10 V

    // Two-wire address: fixed upper bits and broadcast
    localparam logic [2:0]        ADDR_PREFIX   = 3'h4;
    localparam logic [6:0]        ADDR_BCAST    = 7'h00;

    // Timing
    localparam int                CLK_HZ        = 100_000_000;
    localparam int                SLEW_MS       = 60;
    localparam int                BLINK_HALF_US = 500;
    localparam int                BLINK_HALF_CYC =
        BLINK_HALF_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        OUT_OFF  = 2'b00,
        OUT_ON   = 2'b01,
        OUT_OVLD = 2'b10
    } out_state_type;

    typedef struct packed {
        logic fan_fail;
        logic over_temp;
        logic over_volt;
        logic rect_fault;
    } fault_type;

    typedef struct packed {
        logic             valid;
        logic [6:0]       addr;
        logic             read;
        logic             voltage_cmd;
        logic [SET_W-1:0] value;
    } bus_cmd_type;

    typedef struct packed {
        logic [IDX_W-1:0] bay;
        logic [IDX_W-1:0] slot;
        logic [IDX_W-1:0] shelf;
    } serial_addr_type;

endpackage : psu_ctrl_pkg

// ===== hdl/level_sync.sv
`timescale 1ns/100ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync width must be positive");
        end
    end

    always_comb begin
        state_next.first  = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule : level_sync

// ===== hdl/id_level_decode.sv
`timescale 1ns/100ps

module id_level_decode (
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]   bay_mv,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]   rack_mv,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]   slot_mv,
    input  wire logic [psu_ctrl_pkg::SHELF_W-1:0] shelf_cv,
    output logic      [psu_ctrl_pkg::IDX_W-1:0]   bay_index,
    output logic      [psu_ctrl_pkg::IDX_W-1:0]   rack_index,
    output logic      [psu_ctrl_pkg::IDX_W-1:0]   slot_index,
    output logic      [psu_ctrl_pkg::IDX_W-1:0]   shelf_index,
    output logic      [psu_ctrl_pkg::NIB_W-1:0]   address_nibble,
    output logic                                  address_invalid
);
    import psu_ctrl_pkg::*;

    // Ten-step ladder, 0 = no resistor fitted
    function automatic logic [IDX_W-1:0] ladder10(
        input logic [ADC_W-1:0] mv
    );
        logic [IDX_W-1:0] idx;
        logic [ADC_W-1:0] thr;
        idx = 4'hA;
        thr = BAY_TOP_MV;
        for (int i = 1; i < 10; i++) begin
            if (mv > thr && idx == 4'hA) begin
                idx = IDX_W'(i);
            end
            thr = thr - BAY_STEP_MV;
        end
        if (mv >= BAY_INVALID_MV) begin
            idx = 4'h0;
        end
        return idx;
    endfunction : ladder10

    // --------------------------------------------------------------
    // Level classification
    // --------------------------------------------------------------
    // Midway threshold ladders for bay, slot and rack; min/max windows for shelf
    always_comb begin
        bay_index  = ladder10(bay_mv);
        slot_index = ladder10(slot_mv);
        rack_index = 4'h8;
        for (int i = 6; i >= 0; i--) begin
            if (rack_mv > RACK_THR[i]) begin
                rack_index = IDX_W'(i + 1);
            end
        end
        shelf_index = 4'h0;
        for (int i = 0; i < 10; i++) begin
            if (shelf_cv >= SHELF_MIN[i] && shelf_cv <= SHELF_MAX[i]) begin
                shelf_index = IDX_W'(i + 1);
            end
        end
    end

    // --------------------------------------------------------------
    // Address nibble table
    // --------------------------------------------------------------
    always_comb begin
        logic [7:0] n;
        n = 8'h00;
        address_invalid = 1'b0;
        if (bay_index >= 4'h1 && bay_index <= 4'h4 && rack_index <= 4'h4) begin
            n = 8'((rack_index - 4'h1) * 4 + (bay_index - 4'h1));
        end else if (bay_index >= 4'h1 && bay_index <= 4'h5
                     && rack_index >= 4'h6) begin
            n = 8'((rack_index - 4'h6) * 5 + (bay_index - 4'h1));
        end else if (bay_index == 4'h6 || bay_index == 4'h7) begin
            n = 8'((rack_index - 4'h1) * 2 + (bay_index - 4'h6));
        end else if (bay_index >= 4'h8 && bay_index <= 4'hA
                     && rack_index >= 4'h4) begin
            n = 8'((rack_index - 4'h4) * 3 + (bay_index - 4'h8));
        end else begin
            address_invalid = 1'b1;
        end
        address_nibble = n[NIB_W-1:0];
    end
endmodule : id_level_decode

// ===== hdl/psu_address_output_control.sv
`timescale 1ns/100ps

module psu_address_output_control #(
    parameter int SLEW_CYC   = psu_ctrl_pkg::SLEW_MS
                               * (psu_ctrl_pkg::CLK_HZ / 1000),
    // Blink half period in cycles; shortened only for simulation
    parameter int BLINK_HALF = psu_ctrl_pkg::BLINK_HALF_CYC
) (
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]       bay_position_select,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]       rack_group_select,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]       slot_position_select,
    input  wire logic [psu_ctrl_pkg::SHELF_W-1:0]     shelf_level_select,
    input  wire logic [psu_ctrl_pkg::ADC_W-1:0]       output_setpoint_pin,
    input  wire logic                                 protocol_open,
    input  wire logic                                 on_off_n,
    input  wire logic                                 interlock_engaged,
    input  wire logic                                 slot_shorted,
    input  wire logic                                 overload,
    input  wire logic                                 regulation_loss,
    input  wire psu_ctrl_pkg::fault_type              faults,
    input  wire psu_ctrl_pkg::bus_cmd_type            bus_cmd,
    output logic                                      cmd_accept,
    output logic                                      invalid_command,
    output psu_ctrl_pkg::serial_addr_type             serial_addr,
    output logic [6:0]                                twowire_addr,
    output logic                                      address_invalid,
    output logic                                      serial_mode,
    output logic                                      main_output_on,
    output logic [psu_ctrl_pkg::SET_W-1:0]            setpoint_target,
    output logic [psu_ctrl_pkg::SET_W-1:0]            setpoint_now,
    output logic                                      software_control,
    output logic                                      output_good_warning_n,
    output logic                                      fault_oe
);
    import psu_ctrl_pkg::*;

    default clocking ck @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    initial begin
        if (SLEW_CYC < 1) begin
            $error("SLEW_CYC must be at least one cycle");
        end
        if (BLINK_HALF < 1 || BLINK_HALF > 24'hFFFFFF) begin
            $error("BLINK_HALF must fit the blink counter");
        end
    end

    localparam int STEP_CYC = (SLEW_CYC + VOUT_MAX_STEP - 1) / VOUT_MAX_STEP;
    localparam logic [23:0] STEP_CNT = 24'(STEP_CYC);
    localparam logic [23:0] BLINK_CNT = 24'(BLINK_HALF);

    // --------------------------------------------------------------
    // Synchronised pins
    // --------------------------------------------------------------
    logic [4:0] pins_sync;

    level_sync #(
        .WIDTH    (5)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({protocol_open, on_off_n, interlock_engaged,
                    slot_shorted, overload}),
        .sync_out (pins_sync)
    );

    logic proto_open_s;
    logic on_off_n_s;
    logic lock_s;
    logic slot_short_s;
    logic overload_s;

    assign {proto_open_s, on_off_n_s, lock_s, slot_short_s,
            overload_s} = pins_sync;

    // --------------------------------------------------------------
    // Identification decode
    // --------------------------------------------------------------
    logic [IDX_W-1:0] bay_idx;
    logic [IDX_W-1:0] rack_idx;
    logic [IDX_W-1:0] slot_idx;
    logic [IDX_W-1:0] shelf_idx;
    logic [NIB_W-1:0] nibble;
    logic             nib_bad;

    // Converter codes are sampled values, already in this domain
    id_level_decode u_decode (
        .bay_mv          (bay_position_select),
        .rack_mv         (rack_group_select),
        .slot_mv         (slot_position_select),
        .shelf_cv        (shelf_level_select),
        .bay_index       (bay_idx),
        .rack_index      (rack_idx),
        .slot_index      (slot_idx),
        .shelf_index     (shelf_idx),
        .address_nibble  (nibble),
        .address_invalid (nib_bad)
    );

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        out_state_type    out_state;
        logic             sw_latch;
        logic [SET_W-1:0] target;
        logic [SET_W-1:0] now;
        logic [23:0]      slew_cnt;
        logic [23:0]      blink_cnt;
        logic             blink;
        logic             accept;
        logic             invalid;
        serial_addr_type  saddr;
        logic [6:0]       taddr;
        logic             addr_bad;
        logic             serial;
        logic             good_n;
        logic             fault_drv;
    } ctrl_state_type;

    ctrl_state_type state_reg;
    ctrl_state_type state_next;

    logic             enable_ok;
    logic             addr_hit;
    logic [SET_W-1:0] hw_setpoint;
    logic [31:0]      scaled;

    always_comb begin
        state_next = state_reg;
        state_next.serial = ~proto_open_s;

        state_next.saddr.bay   = bay_idx;
        state_next.saddr.slot  = slot_idx;
        state_next.saddr.shelf = shelf_idx;
        state_next.taddr    = {ADDR_PREFIX, nibble};
        state_next.addr_bad = nib_bad | (bay_idx == 4'h0);

        scaled = 32'(output_setpoint_pin - SETP_LOW_MV) * 32'(VOUT_SPAN_CV)
                 / 32'(SETP_HIGH_MV - SETP_LOW_MV);
        if (output_setpoint_pin > SETP_HIGH_MV) begin
            hw_setpoint = VOUT_DEF_CV;
        end else if (output_setpoint_pin < SETP_LOW_MV) begin
            hw_setpoint = VOUT_MIN_CV;
        end else begin
            hw_setpoint = VOUT_MIN_CV + scaled[SET_W-1:0];
        end

        addr_hit = bus_cmd.valid && (bus_cmd.addr == state_reg.taddr
                   || bus_cmd.addr == ADDR_BCAST) && !state_reg.serial;
        state_next.accept  = 1'b0;
        state_next.invalid = 1'b0;
        if (addr_hit) begin
            if (bus_cmd.read && bus_cmd.addr == ADDR_BCAST) begin
                state_next.invalid = 1'b1;
            end else begin
                state_next.accept = 1'b1;
                if (!bus_cmd.read && bus_cmd.voltage_cmd) begin
                    state_next.sw_latch = 1'b1;
                    state_next.target   = bus_cmd.value;
                end
            end
        end
        if (!state_reg.sw_latch && !state_next.sw_latch) begin
            state_next.target = hw_setpoint;
        end

        // Ramp at 10 V per 60 ms
        if (state_reg.now != state_reg.target) begin
            if (state_reg.slew_cnt >= STEP_CNT - 24'h1) begin
                state_next.slew_cnt = '0;
                if (state_reg.now < state_reg.target) begin
                    state_next.now = state_reg.now + 16'h1;
                end else begin
                    state_next.now = state_reg.now - 16'h1;
                end
            end else begin
                state_next.slew_cnt = state_reg.slew_cnt + 24'h1;
            end
        end else begin
            state_next.slew_cnt = '0;
        end

        enable_ok = lock_s && (state_reg.serial
                    ? (slot_idx != 4'h0)
                    : (!on_off_n_s && slot_short_s));

        case (state_reg.out_state)
            OUT_OFF: begin
                if (enable_ok) begin
                    state_next.out_state = OUT_ON;
                end
            end
            OUT_ON: begin
                if (!enable_ok) begin
                    state_next.out_state = OUT_OFF;
                end else if (overload_s) begin
                    state_next.out_state = OUT_OVLD;
                end
            end
            OUT_OVLD: begin
                if (!enable_ok) begin
                    state_next.out_state = OUT_OFF;
                end else if (!overload_s) begin
                    state_next.out_state = OUT_ON;
                end
            end
            default: begin
                state_next.out_state = OUT_OFF;
            end
        endcase

        if (state_reg.out_state == OUT_OVLD) begin
            if (state_reg.blink_cnt >= BLINK_CNT - 24'h1) begin
                state_next.blink_cnt = '0;
                state_next.blink     = ~state_reg.blink;
            end else begin
                state_next.blink_cnt = state_reg.blink_cnt + 24'h1;
            end
        end else begin
            state_next.blink_cnt = '0;
            state_next.blink     = 1'b0;
        end

        case (state_next.out_state)
            OUT_ON:   state_next.good_n = ~regulation_loss;
            OUT_OVLD: state_next.good_n = state_next.blink;
            default:  state_next.good_n = 1'b0;
        endcase

        state_next.fault_drv = |faults;
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.target    <= VOUT_DEF_CV;
            state_reg.now       <= VOUT_DEF_CV;
            state_reg.out_state <= OUT_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cmd_accept            = state_reg.accept;
    assign invalid_command       = state_reg.invalid;
    assign serial_addr           = state_reg.saddr;
    assign twowire_addr          = state_reg.taddr;
    assign address_invalid       = state_reg.addr_bad;
    assign serial_mode           = state_reg.serial;
    assign main_output_on        = state_reg.out_state != OUT_OFF;
    assign setpoint_target       = state_reg.target;
    assign setpoint_now          = state_reg.now;
    assign software_control      = state_reg.sw_latch;
    assign output_good_warning_n = state_reg.good_n;
    assign fault_oe              = state_reg.fault_drv;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    AST_BCAST_READ: assert property (
        addr_hit && bus_cmd.read && bus_cmd.addr == ADDR_BCAST
        |=> invalid_command && !cmd_accept)
        else $error("broadcast read not rejected");

    AST_LATCH_HOLD: assert property (
        software_control |=> software_control)
        else $error("software latch dropped");

    AST_OFF_LOCK: assert property (!lock_s |=> !main_output_on)
        else $error("output on without interlock");

    AST_ONOFF_N: assert property (
        !serial_mode && on_off_n_s |=> !main_output_on)
        else $error("output on with on/off released");

    AST_SLOT_LOCK: assert property (
        !serial_mode && !slot_short_s |=> !main_output_on)
        else $error("output on without slot short");

    AST_GOOD_OFF: assert property (
        !main_output_on |-> !output_good_warning_n)
        else $error("good warning high while off");

    AST_BLINK: assert property (
        $rose(output_good_warning_n) && state_reg.out_state == OUT_OVLD
        ##1 state_reg.out_state == OUT_OVLD [*8]
        |-> output_good_warning_n)
        else $error("overload blink too fast");

    AST_FAULT: assert property (|faults |=> fault_oe)
        else $error("fault not driven");

    AST_SLEW_DIR: assert property (
        setpoint_now < setpoint_target
        |=> setpoint_now >= $past(setpoint_now))
        else $error("setpoint moved away from target");

    AST_ADDR: assert property (
        bus_cmd.valid && bus_cmd.addr != twowire_addr
        && bus_cmd.addr != ADDR_BCAST |=> !cmd_accept && !invalid_command)
        else $error("answer to a foreign address");
endmodule : psu_address_output_control

// ===== tb/host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host issuing one-cycle bus commands
// ----------------------------------------
module host_model
    import psu_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [6:0]  addr,
    input  wire logic        rd,
    input  wire logic [15:0] value,
    output bus_cmd_type      bus_cmd
);
    always_ff @(posedge ref_clk) begin
        bus_cmd <= '0;
        if (go) begin
            bus_cmd <= '{1'b1, addr, rd, ~rd, value};
        end
    end
endmodule : host_model

// ===== tb/psu_address_output_control_bench.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench
// ----------------------------------------
module psu_address_output_control_bench;
    import psu_ctrl_pkg::*;
    logic ref_clk=0, rst=1, protocol_open=1, on_off_n=1, interlock_engaged=0;
    logic slot_shorted=0, overload=0, regulation_loss=0, go=0, rd=0;
    logic [11:0] bay_position_select=0, rack_group_select=0;
    logic [11:0] slot_position_select=12'hCE4, output_setpoint_pin=0;
    logic [15:0] shelf_level_select=0, value=0;
    logic [6:0]  addr=0, twowire_addr;
    fault_type   faults='0;
    bus_cmd_type bus_cmd;
    serial_addr_type serial_addr;
    logic cmd_accept, invalid_command, address_invalid, serial_mode;
    logic main_output_on, software_control, output_good_warning_n, fault_oe;
    logic [15:0] setpoint_target, setpoint_now;
    int miscompares=0, checks_done=0, cyc=0, b, r, n;
    int rack_mv[8] = '{3300, 2800, 2300, 1800, 1400, 1000, 500, 0};
    logic [1:0] exp_q[$];
    logic [1:0] exp_ans, seen_ans;

    psu_address_output_control #(.SLEW_CYC(1000), .BLINK_HALF(20))
        psu_address_output_control_inst (.*);
    host_model host_model_inst (.ref_clk, .go, .addr, .rd, .value, .bus_cmd);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic wt(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : wt

    // Answer code 1 accept, 2 invalid, 0 none expected
    task automatic send(logic [6:0] a, logic r_in, logic [15:0] v,
                        logic [1:0] e);
        if (e != 0) exp_q.push_back(e);
        addr = a;
        rd = r_in;
        value = v;
        go = 1;
        wt(1);
        go = 0;
        wt(3);
    endtask : send

    task automatic test_done;
        $display("Checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // Answers are one-cycle pulses, taken off the queue as they appear
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            test_done();
        end else if (cmd_accept === 1'b1 || invalid_command === 1'b1) begin
            exp_ans = exp_q.size() ? exp_q.pop_front() : 2'h0;
            seen_ans = {invalid_command, cmd_accept};
            cmp("answer", 16'(exp_ans), 16'(seen_ans));
        end
    end

    initial begin
        n = $urandom(4);
        wt(2);
        rst = 0;
        wt(1);
        cmp("target", VOUT_DEF_CV, setpoint_target);
        cmp("swctl", 0, software_control);
        for (int i = 0; i < 14; i++) begin
            b = $urandom_range(10, 1);
            r = $urandom_range(8, 1);
            bay_position_select = 12'(3000 - 330 * (b - 1));
            rack_group_select = 12'(rack_mv[r-1]);
            n = (b < 5 && r < 5) ? (r-1)*4+b-1 :
                (b < 6 && r > 5) ? (r-6)*5+b-1 :
                (b > 5 && b < 8) ? (r-1)*2+b-6 :
                (b > 7 && r > 3) ? (r-4)*3+b-8 : -1;
            wt(3);
            cmp("inv", 16'(n < 0), address_invalid);
            if (n >= 0) begin
                cmp("addr", {9'h0, ADDR_PREFIX, 4'(n)}, twowire_addr);
            end
        end
        bay_position_select = 12'hCE4;
        wt(3);
        cmp("bayinv", 1, address_invalid);
        $display("address test done");
        bay_position_select = 12'hBB8;
        rack_group_select = 12'hCE4;
        wt(3);
        send(7'h00, 1, 0, 2);
        send(7'h41, 0, 16'h1000, 0);
        cmp("refused", 0, software_control);
        send(7'h40, 0, 16'h0C00, 1);
        output_setpoint_pin = 12'h7D0;
        wt(3);
        cmp("latched", 16'h0C00, setpoint_target);
        cmp("swctl", 1, software_control);
        send(7'h40, 1, 0, 1);
        wt(1010);
        cmp("ramp", 16'h0C00, setpoint_now);
        $display("command test done");
        rst = 1;
        wt(2);
        rst = 0;
        wt(3);
        cmp("swclr", 0, software_control);
        n = 2300 + (2000 - 100) * 4200 / 2900;
        cmp("pin", 16'(n), setpoint_target);
        output_setpoint_pin = 12'hC00;
        wt(3);
        cmp("pinhigh", VOUT_DEF_CV, setpoint_target);
        $display("reset test done");
        interlock_engaged = 1;
        slot_shorted = 1;
        on_off_n = 0;
        wt(5);
        cmp("on", 1, main_output_on);
        cmp("good", 1, output_good_warning_n);
        regulation_loss = 1;
        wt(2);
        cmp("warn", 0, output_good_warning_n);
        regulation_loss = 0;
        overload = 1;
        wt(10);
        cmp("blink0", 0, output_good_warning_n);
        cmp("ovldon", 1, main_output_on);
        wt(20);
        cmp("blink1", 1, output_good_warning_n);
        wt(20);
        cmp("blink2", 0, output_good_warning_n);
        overload = 0;
        on_off_n = 1;
        faults = 4'($urandom_range(15, 1));
        wt(5);
        cmp("off", 0, main_output_on);
        cmp("fault", 1, fault_oe);
        faults = '0;
        $display("output test done");
        b = $urandom_range(10, 1);
        r = $urandom_range(10, 1);
        protocol_open = 0;
        slot_shorted = 0;
        slot_position_select = 12'(3000 - 330 * (b - 1));
        shelf_level_select = 16'(250 * r);
        wt(5);
        cmp("serial", 1, serial_mode);
        cmp("son", 1, main_output_on);
        cmp("saddr", {4'h1, 4'(b), 4'(r)}, serial_addr);
        cmp("clear", 0, fault_oe);
        slot_position_select = 12'hCE4;
        wt(5);
        cmp("soff", 0, main_output_on);
        cmp("queue", 0, 16'(exp_q.size()));
        $display("serial test done");
        test_done();
    end
endmodule : psu_address_output_control_bench
